/* slope_adc_defines.vh */
// Register offsets, field positions and reset values of the slope converter control
`ifndef SLOPE_ADC_DEFINES_VH
`define SLOPE_ADC_DEFINES_VH

// Printed register indices; byte address is four times the index
`define IDX_RAMP_TIMER_LOW    8'h0E
`define IDX_RAMP_TIMER_HIGH   8'h0F
`define IDX_CAPTURE_LOW       8'h15
`define IDX_CAPTURE_HIGH      8'h16
`define IDX_CONV_CONTROL_A    8'h1F
`define IDX_CONV_CONTROL_B    8'h20
`define IDX_PERIPH_IRQ_FLAGS  8'h0C
`define IDX_PERIPH_IRQ_ENABLE 8'h21
`define IDX_CORE_IRQ_CONTROL  8'h0B
`define IDX_POWER_CONTROL     8'h22

// Field positions
`define CTLA_HOLD_BIT   1
`define CTLA_CHAN_LSB   4
`define CTLB_CUR_LSB    4
`define FLAG_OVF_BIT    0
`define FLAG_CAP_BIT    1
`define CORE_GIE_BIT    7
`define CORE_PERIPHERAL_IRQ_ENABLE_BIT   6
`define PWR_CONV_BIT    0
`define PWR_REF_BIT     5

// Reset values
`define CTLA_RESET      8'h02
`define CTLB_RESET      8'h00
`define PWR_RESET       8'h21
`define TIMER_RESET     16'h0000

// Minimum hold time in microseconds, and in cycles at 10 MHz (exact product of the two)
`define CLK_MHZ         10
`define HOLD_MIN_US     200
`define HOLD_MIN_CYC    (`HOLD_MIN_US * `CLK_MHZ)

`endif

/* comparator_sync.v */
// Two-stage synchroniser and falling-edge detector for the ramp comparator
`timescale 1ns/100ps
`default_nettype none
module comparator_sync (
	// Clock and reset
	input  wire clk,
	input  wire rst_b,
	// Comparator
	input  wire comp_in,
	output reg  fall_pulse
);
	reg meta_q;
	reg sync_q;
	reg last_q;

	// Idle level is high so no false edge after reset
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q     <= 1'b1;
			sync_q     <= 1'b1;
			last_q     <= 1'b1;
			fall_pulse <= 1'b0;
		end else begin
			meta_q     <= comp_in;
			sync_q     <= meta_q;
			last_q     <= sync_q;
			fall_pulse <= last_q & ~sync_q;
		end
	end
endmodule
`default_nettype wire

/* slope_adc_timer_capture.v */
// Slope converter timer, capture, flags and APB register file
//
// Function
// - Hold stops timer and disables ramp current
// - Sixteen-bit up timer, one per cycle
// - Timer cleared only by power-up reset
// - Clearing hold starts counting and charging
// - Comparator falling edge captures timer value
// - Capture sets capture flag
// - Capture flag raised once per conversion
// - Timer keeps counting after capture
// - Wrap sets overflow flag, counting continues
// - Irq needs flag, own, global, peripheral enables
// - Timer and capture as byte registers
// - Low byte before high disables timer
// - Four-bit channel select drives mux
// - Four-bit current code, zero means off
// - Powered only while both power-downs clear
// - Hold control set at power-on
//
// Register word indices
// Index 0x0B core interrupt control: bit 7 global, bit 6 peripheral
// Index 0x0C interrupt flags: bit 1 capture, bit 0 overflow
// Index 0x0E ramp timer low byte
// Index 0x0F ramp timer high byte
// Index 0x15 capture low byte
// Index 0x16 capture high byte
// Index 0x1F control A: [7:4] channel, bit 1 hold, bit 3 reads zero
// Index 0x20 control B: [7:4] ramp current code
// Index 0x21 interrupt enables: bit 1 capture, bit 0 overflow
// Index 0x22 power control: bit 0 converter off, bit 5 reference off
`timescale 1ns/100ps
`default_nettype none
`include "slope_adc_defines.vh"
module slope_adc_timer_capture #(
	parameter TIMER_W = 16
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Analog side
	input  wire        comp_out,
	output reg  [3:0]  channel_select,
	output reg  [3:0]  current_select,
	output reg         ramp_discharge,
	output reg         converter_power_on,
	output reg         reference_power_on,
	// CPU interrupt
	output reg         irq
);
	////////////////////////////////////////////////////////////////
	reg  [TIMER_W-1:0] ramp_timer_q;
	reg  [TIMER_W-1:0] capture_value_q;
	reg  [7:0]         conv_control_a_q;
	reg  [7:0]         conv_control_b_q;
	reg  [7:0]         power_control_q;
	reg  [1:0]         irq_enables_q;
	reg  [1:0]         core_irq_q;
	reg                capture_flag_q;
	reg                overflow_flag_q;
	reg                captured_q;
	reg                order_ok_q;
	reg                high_written_q;
	wire               cap_event;
	wire               hold;
	wire               running;
	wire               wr;
	wire [9:0]         idx;
	wire [7:0]         wb;
	wire               hit;
	wire               cap_take;
	wire               wrap_now;

	// Register decode and per-register write strobes
	wire               sel_timer_low;
	wire               sel_timer_high;
	wire               sel_cap_low;
	wire               sel_cap_high;
	wire               sel_ctl_a;
	wire               sel_ctl_b;
	wire               sel_flags;
	wire               sel_enables;
	wire               sel_core;
	wire               sel_power;
	wire               wr_timer_low;
	wire               wr_timer_high;
	wire               wr_cap_low;
	wire               wr_cap_high;
	wire               wr_ctl_a;
	wire               wr_ctl_b;
	wire               wr_flags;
	wire               wr_enables;
	wire               wr_core;
	wire               wr_power;

	comparator_sync comparator_sync_inst (
		.clk        (clk),
		.rst_b      (rst_b),
		.comp_in    (comp_out),
		.fall_pulse (cap_event)
	);

	assign hold    = conv_control_a_q[`CTLA_HOLD_BIT];
	// Timer runs only with hold clear and a valid load order
	assign running = ~hold & order_ok_q;
	assign idx     = paddr[11:2];
	assign wb      = pwdata[7:0];
	// Zero-wait slave: access phase completes in its first cycle
	assign wr      = psel & penable & pwrite & ~pslverr;

	////////////////////////////////////////////////////////////////
	// Register decode; the two upper index bits must be zero
	assign sel_timer_low  = (idx == {2'b00, `IDX_RAMP_TIMER_LOW});
	assign sel_timer_high = (idx == {2'b00, `IDX_RAMP_TIMER_HIGH});
	assign sel_cap_low    = (idx == {2'b00, `IDX_CAPTURE_LOW});
	assign sel_cap_high   = (idx == {2'b00, `IDX_CAPTURE_HIGH});
	assign sel_ctl_a      = (idx == {2'b00, `IDX_CONV_CONTROL_A});
	assign sel_ctl_b      = (idx == {2'b00, `IDX_CONV_CONTROL_B});
	assign sel_flags      = (idx == {2'b00, `IDX_PERIPH_IRQ_FLAGS});
	assign sel_enables    = (idx == {2'b00, `IDX_PERIPH_IRQ_ENABLE});
	assign sel_core       = (idx == {2'b00, `IDX_CORE_IRQ_CONTROL});
	assign sel_power      = (idx == {2'b00, `IDX_POWER_CONTROL});
	assign hit = sel_timer_low | sel_timer_high | sel_cap_low | sel_cap_high
		| sel_ctl_a | sel_ctl_b | sel_flags | sel_enables | sel_core | sel_power;

	// Strobes stand only in the access cycle, so each write lands once
	assign wr_timer_low  = wr & sel_timer_low;
	assign wr_timer_high = wr & sel_timer_high;
	assign wr_cap_low    = wr & sel_cap_low;
	assign wr_cap_high   = wr & sel_cap_high;
	assign wr_ctl_a      = wr & sel_ctl_a;
	assign wr_ctl_b      = wr & sel_ctl_b;
	assign wr_flags      = wr & sel_flags;
	assign wr_enables    = wr & sel_enables;
	assign wr_core       = wr & sel_core;
	assign wr_power      = wr & sel_power;

	// Only the first falling edge after the hold is released captures
	assign cap_take = cap_event & running & ~captured_q;
	// Last count before the wrap to zero
	assign wrap_now = running & (ramp_timer_q == {TIMER_W{1'b1}});

	////////////////////////////////////////////////////////////////
	// APB handshake: pready and pslverr are raised in the setup cycle
	// so they stand registered during the single access cycle
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
		end
	end

	// Read data is latched in the setup cycle, so reads have no side effect
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable) begin
			prdata <= 32'h00000000;
			case (idx)
			{2'b00, `IDX_RAMP_TIMER_LOW}:    prdata[7:0] <= ramp_timer_q[7:0];
			{2'b00, `IDX_RAMP_TIMER_HIGH}:   prdata[7:0] <= ramp_timer_q[15:8];
			{2'b00, `IDX_CAPTURE_LOW}:       prdata[7:0] <= capture_value_q[7:0];
			{2'b00, `IDX_CAPTURE_HIGH}:      prdata[7:0] <= capture_value_q[15:8];
			{2'b00, `IDX_CONV_CONTROL_A}:    prdata[7:0] <= conv_control_a_q;
			{2'b00, `IDX_CONV_CONTROL_B}:    prdata[7:0] <= conv_control_b_q;
			{2'b00, `IDX_PERIPH_IRQ_FLAGS}:
				prdata[1:0] <= {capture_flag_q, overflow_flag_q};
			{2'b00, `IDX_PERIPH_IRQ_ENABLE}: prdata[1:0] <= irq_enables_q;
			{2'b00, `IDX_CORE_IRQ_CONTROL}:  prdata[7:6] <= core_irq_q;
			{2'b00, `IDX_POWER_CONTROL}:     prdata[7:0] <= power_control_q;
			default:                         prdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Control registers
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			conv_control_a_q <= `CTLA_RESET;
			conv_control_b_q <= `CTLB_RESET;
			power_control_q  <= `PWR_RESET;
			irq_enables_q    <= 2'b00;
			core_irq_q       <= 2'b00;
		end else begin
			if (wr_ctl_a)
				conv_control_a_q <= wb & 8'hF7;
			if (wr_ctl_b)
				conv_control_b_q <= wb;
			if (wr_power)
				power_control_q <= wb & 8'h21;
			if (wr_enables)
				irq_enables_q <= wb[1:0];
			if (wr_core)
				core_irq_q <= wb[7:6];
		end
	end

	////////////////////////////////////////////////////////////////
	// Timer with byte-wise load. Load order: high then low arms the
	// timer; a low write without a preceding high write disarms it.
	// Loads are not interlocked against a running conversion.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ramp_timer_q   <= `TIMER_RESET;
			order_ok_q     <= 1'b1;
			high_written_q <= 1'b0;
		end else if (wr_timer_high) begin
			ramp_timer_q[15:8] <= wb;
			high_written_q     <= 1'b1;
		end else if (wr_timer_low) begin
			ramp_timer_q[7:0] <= wb;
			order_ok_q        <= high_written_q;
			high_written_q    <= 1'b0;
		end else if (running) begin
			// Wraps freely past all ones; capture does not stop it
			ramp_timer_q <= ramp_timer_q + {{(TIMER_W-1){1'b0}}, 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////
	// Capture register and the once-per-conversion latch
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			capture_value_q <= `TIMER_RESET;
			captured_q      <= 1'b0;
		end else begin
			// A byte write in the same cycle as a capture is lost
			if (cap_take)
				capture_value_q <= ramp_timer_q;
			else if (wr_cap_low)
				capture_value_q[7:0] <= wb;
			else if (wr_cap_high)
				capture_value_q[15:8] <= wb;
			// A new conversion cycle begins with the hold control
			if (hold)
				captured_q <= 1'b0;
			else if (cap_event & running)
				captured_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Flags: hardware set wins over software clear in the same cycle
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			capture_flag_q  <= 1'b0;
			overflow_flag_q <= 1'b0;
		end else begin
			if (cap_take)
				capture_flag_q <= 1'b1;
			else if (wr_flags)
				capture_flag_q <= wb[`FLAG_CAP_BIT];
			if (wrap_now)
				overflow_flag_q <= 1'b1;
			else if (wr_flags)
				overflow_flag_q <= wb[`FLAG_OVF_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// Analog controls and interrupt request, all registered
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			channel_select     <= 4'h0;
			current_select     <= 4'h0;
			ramp_discharge     <= 1'b1;
			converter_power_on <= 1'b0;
			reference_power_on <= 1'b0;
			irq                <= 1'b0;
		end else begin
			channel_select     <= conv_control_a_q[`CTLA_CHAN_LSB+3:`CTLA_CHAN_LSB];
			// Source off while held so the capacitor can discharge
			current_select     <= hold ? 4'h0
				: conv_control_b_q[`CTLB_CUR_LSB+3:`CTLB_CUR_LSB];
			ramp_discharge     <= hold;
			converter_power_on <= ~power_control_q[`PWR_CONV_BIT]
				& ~power_control_q[`PWR_REF_BIT];
			reference_power_on <= ~power_control_q[`PWR_CONV_BIT]
				& ~power_control_q[`PWR_REF_BIT];
			// Level request; it drops the cycle after its flag is cleared
			irq <= core_irq_q[1] & core_irq_q[0]
				& ((capture_flag_q & irq_enables_q[`FLAG_CAP_BIT])
				| (overflow_flag_q & irq_enables_q[`FLAG_OVF_BIT]));
		end
	end
endmodule
`default_nettype wire

/* slope_adc_props.sv */
// Port checker for the slope converter control
`timescale 1ns/100ps
`default_nettype none
module slope_adc_props (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic [3:0]  channel_select,
	input wire logic [3:0]  current_select,
	input wire logic        ramp_discharge,
	input wire logic        converter_power_on,
	input wire logic        reference_power_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		pready ##1 !pready;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> s_done)
		else $error("no single ready after setup");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("slave error outside access");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_hold_no_current: assert property (ramp_discharge |-> current_select == 4'h0)
		else $error("current on while held");
	a_power_pair: assert property (converter_power_on == reference_power_on)
		else $error("power outputs differ");
	a_hold_at_reset: assert property ($rose(rst_b) |-> ramp_discharge)
		else $error("hold clear after reset");
	a_chan_by_write: assert property ($changed(channel_select) |->
		$past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
		else $error("channel changed without write");
	a_hold_by_write: assert property ($changed(ramp_discharge) |->
		$past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
		else $error("hold changed without write");
endmodule
`default_nettype wire

/* ramp_model.sv */
// Behavioural ramp capacitor, input source and comparator
`timescale 1ns/100ps
`default_nettype none
module ramp_model (
	input wire logic       clk,
	input wire logic [3:0] chan,
	input wire logic [3:0] cur,
	input wire logic       disch,
	input wire logic       pwr,
	input wire logic       chatter,
	output var logic       comp_out
);
	int ramp = 0;
	always @(posedge clk) begin
		if (disch || !pwr) ramp <= 0;
		else ramp <= ramp + cur;
	end
	// Reserved channels never trip; chatter makes repeated falls after a trip
	always @* begin
		comp_out = chan > 4'hD || ramp <= (chan + 1) * 64;
		if (chatter && ramp[3]) comp_out = 1'b1;
	end
endmodule
`default_nettype wire

/* slope_adc_timer_capture_test.sv */
// Self-checking bench for the slope converter control
`timescale 1ns/100ps
`default_nettype none
`include "slope_adc_defines.vh"
module slope_adc_timer_capture_test;
	logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, chatter = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, lf = 73615;
	logic        pready, pslverr, er, comp_out, irq, disch, cpw, rpw;
	logic [3:0]  chan, cur, ch, c;
	logic [15:0] v, cap;
	int          n_mismatch = 0, samples_checked = 0, t;
	always #50 clk = ~clk;
	slope_adc_timer_capture slope_adc_timer_capture_inst (.clk(clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_out(comp_out),
		.channel_select(chan), .current_select(cur), .ramp_discharge(disch),
		.converter_power_on(cpw), .reference_power_on(rpw), .irq(irq));
	ramp_model ramp_model_inst (.clk(clk), .chan(chan), .cur(cur), .disch(disch),
		.pwr(cpw), .chatter(chatter), .comp_out(comp_out));
	////////////////////////////////////////////////////////////////
	function logic [31:0] rnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {2'b00, ix, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rdc(input string nm, input logic [7:0] ix, input logic [31:0] e);
		apb(0, ix, 8'h00);
		chk(nm, rd, e);
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task conv(input logic [3:0] h, input logic [3:0] k, input logic [15:0] p);
		apb(1, `IDX_CONV_CONTROL_A, {h, 4'h2});
		apb(1, `IDX_PERIPH_IRQ_FLAGS, 8'h00);
		apb(1, `IDX_CONV_CONTROL_B, {k, 4'h0});
		apb(1, `IDX_RAMP_TIMER_HIGH, p[15:8]);
		apb(1, `IDX_RAMP_TIMER_LOW, p[7:0]);
		repeat (`HOLD_MIN_CYC) @(posedge clk);
		apb(1, `IDX_CONV_CONTROL_A, {h, 4'h0});
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#(100 * 60000);
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1;
		rdc("tmr_lo", `IDX_RAMP_TIMER_LOW, 0);
		rdc("cap_hi", `IDX_CAPTURE_HIGH, 0);
		rdc("ctl_a", `IDX_CONV_CONTROL_A, 32'h02);
		rdc("unmapped", 8'h3F, 0);
		chk("slverr", er, 1);
		apb(1, `IDX_POWER_CONTROL, 8'h20);
		tick(3);
		chk("pwr_half", {cpw, rpw}, 0);
		apb(1, `IDX_POWER_CONTROL, 8'h00);
		tick(3);
		chk("pwr_on", {cpw, rpw}, 3);
		for (int i = 0; i < 16; i++) begin
			apb(1, `IDX_CONV_CONTROL_A, {i[3:0], 4'h2});
			tick(3);
			chk("chan", chan, i[3:0]);
		end
		conv(4'hE, 4'h0, 16'h1234);
		apb(1, `IDX_CONV_CONTROL_A, 8'hE2);
		tick(20);
		// Three counts pass between the release and the next hold write
		rdc("tmr_held", `IDX_RAMP_TIMER_LOW, 32'h34 + 3);
		apb(1, `IDX_RAMP_TIMER_LOW, 8'h00);
		apb(1, `IDX_CONV_CONTROL_A, 8'hE0);
		for (int i = 0; i < 16; i++) begin
			apb(1, `IDX_CONV_CONTROL_B, {i[3:0], 4'h0});
			tick(3);
			chk("cur", cur, i[3:0]);
		end
		rdc("tmr_dead", `IDX_RAMP_TIMER_LOW, 0);
		repeat (5) begin
			lf = rnd(lf);
			ch = lf % 14;
			c = 1 + lf[15:8] % 15;
			v = {1'b0, lf[30:16]};
			t = ((ch + 1) * 64) / c;
			conv(ch, c, v);
			tick(t + 30);
			rdc("cap_flag", `IDX_PERIPH_IRQ_FLAGS, 32'h02);
			apb(1, `IDX_CONV_CONTROL_A, {ch, 4'h2});
			apb(0, `IDX_CAPTURE_LOW, 8'h00);
			cap[7:0] = rd[7:0];
			apb(0, `IDX_CAPTURE_HIGH, 8'h00);
			cap[15:8] = rd[7:0];
			// Trip after t+1 steps, sync chain adds four; hold lands t+35 counts in
			chk("cap_win", cap, v + t + 5);
			apb(0, `IDX_RAMP_TIMER_LOW, 8'h00);
			cap[7:0] = rd[7:0];
			apb(0, `IDX_RAMP_TIMER_HIGH, 8'h00);
			cap[15:8] = rd[7:0];
			chk("runs_on", cap, v + t + 35);
		end
		chatter <= 1;
		conv(4'h0, 4'h4, 16'h0100);
		tick(40);
		apb(1, `IDX_PERIPH_IRQ_FLAGS, 8'h00);
		tick(100);
		rdc("once", `IDX_PERIPH_IRQ_FLAGS, 0);
		chatter <= 0;
		apb(1, `IDX_PERIPH_IRQ_FLAGS, 8'h02);
		apb(1, `IDX_PERIPH_IRQ_ENABLE, 8'h02);
		apb(1, `IDX_CORE_IRQ_CONTROL, 8'h40);
		tick(3);
		chk("irq_off", irq, 0);
		apb(1, `IDX_CORE_IRQ_CONTROL, 8'hC0);
		tick(3);
		chk("irq_on", irq, 1);
		conv(4'h0, 4'h0, 16'hFFF0);
		tick(40);
		rdc("ovf", `IDX_PERIPH_IRQ_FLAGS, 32'h01);
		chk("irq_ovf", irq, 0);
		apb(1, `IDX_CONV_CONTROL_A, 8'h02);
		rdc("wrap", `IDX_RAMP_TIMER_HIGH, 0);
		tally_and_finish;
	end
endmodule
bind slope_adc_timer_capture slope_adc_props props_inst (.clk(clk), .rst_b(rst_b),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.prdata(prdata), .channel_select(channel_select), .current_select(current_select),
	.ramp_discharge(ramp_discharge), .converter_power_on(converter_power_on),
	.reference_power_on(reference_power_on));
`default_nettype wire
